/* File: near_limit_pkg.sv */
// constants, register map and field layout for the near flag and speed limit
package near_limit_pkg;
	localparam int DEV_W = 32;
	localparam int SPD_W = 16;
	localparam logic [31:0] NEAR_WIDTH_MAX = 32'h4000_0000;
	localparam logic [31:0] DONE_WIDTH_DEF = 32'h0000_0007;
	localparam logic [15:0] TORQUE_LIMIT_MAX = 16'h2710;
	localparam logic [15:0] TORQUE_LIMIT_DEF = 16'h2710;
	localparam logic [15:0] MAX_SPEED_DEF = 16'h2710;
	localparam logic [15:0] OVERSPEED_DEF = 16'h2AF8;
	localparam logic [11:0] A_NEAR_WIDTH = 12'h000;
	localparam logic [11:0] A_DONE_WIDTH = 12'h004;
	localparam logic [11:0] A_CONFIG = 12'h008;
	localparam logic [11:0] A_ROT_LIMIT = 12'h00C;
	localparam logic [11:0] A_LIN_LIMIT = 12'h010;
	localparam logic [11:0] A_MAX_SPEED = 12'h014;
	localparam logic [11:0] A_OVERSPEED = 12'h018;
	localparam logic [11:0] A_HOST_LIMIT = 12'h01C;
	localparam logic [11:0] A_STATUS = 12'h020;
	localparam logic [11:0] A_IRQ_STAT = 12'h024;
	localparam logic [11:0] A_IRQ_MASK = 12'h028;
	localparam logic [11:0] A_APPLIED = 12'h02C;
	// config fields
	localparam int CF_ALLOC_MODE = 0;
	localparam int CF_SRC_SEL = 2;
	localparam int CF_INT_SEL = 3;
	localparam int CF_LINEAR = 4;
	localparam int CF_NEAR_COMPAT = 5;
	localparam int CF_NEAR_MULTI = 6;
	localparam int CF_VLT_COMPAT = 7;
	localparam int CF_VLT_MULTI = 8;
	localparam int CF_DONE_EN = 9;
	localparam logic [9:0] CONFIG_DEF = 10'h205;
	typedef enum logic [1:0]
	{
		ALLOC_RSVD = 2'h0,
		ALLOC_COMPAT = 2'h1,
		ALLOC_MULTI = 2'h2
	} alloc_mode_t;
	localparam int NEV = 3;
endpackage

/* File: near_flag_and_torque_speed_limit.sv */
// near and done flags, torque-control speed limiting, apb registers
`timescale 1ns/1ps
module near_flag_and_torque_speed_limit
(
	input  wire logic                            i_mclk,
	input  wire logic                            i_rst_n,
	input  wire logic                            i_ce,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic signed [near_limit_pkg::DEV_W-1:0] i_deviation,
	input  wire logic                            i_torque_mode,
	input  wire logic [near_limit_pkg::SPD_W-1:0] i_speed_cmd,
	input  wire logic [near_limit_pkg::SPD_W-1:0] i_host_speed_limit_cmd,
	input  wire logic                            i_host_limit_valid,
	output logic      [near_limit_pkg::SPD_W-1:0] o_speed_ref,
	output logic                                 o_near_out,
	output logic                                 o_positioning_done_out,
	output logic                                 o_speed_limit_active_out,
	output logic                                 o_irq
);
	import near_limit_pkg::*;

	logic [31:0]      near_width;
	logic [31:0]      positioning_done_width;
	logic [9:0]       config_reg;
	logic [15:0]      rotary_torque_speed_limit;
	logic [15:0]      linear_force_speed_limit;
	logic [15:0]      max_speed;
	logic [15:0]      overspeed;
	logic [15:0]      host_speed_limit_cmd;
	logic [NEV-1:0]   irq_stat;
	logic [NEV-1:0]   irq_mask;
	logic             src_external;
	logic             int_overspeed;
	logic             near_flag;
	logic             done_flag;
	logic             limit_flag;
	logic [15:0]      applied_limit;
	logic [31:0]      abs_dev;
	logic [15:0]      prog_limit;
	logic [15:0]      ceiling;
	logic [15:0]      internal_limit;
	logic [15:0]      next_limit;
	logic             next_near;
	logic             next_done;
	logic             next_limit_flag;
	logic             near_alloc;
	logic             vlt_alloc;
	logic             wr;
	logic             rd;
	logic [NEV-1:0]   events;
	alloc_mode_t      amode;

	assign wr = psel && penable && pwrite && i_ce;
	assign rd = psel && !penable && !pwrite;
	assign amode = alloc_mode_t'(config_reg[CF_ALLOC_MODE +: 2]);

	// magnitude of signed deviation
	always_comb
	begin
		abs_dev = i_deviation[DEV_W-1] ? 32'(-i_deviation)
			: 32'(i_deviation);
	end

	// limit selection path
	always_comb
	begin
		prog_limit = config_reg[CF_LINEAR] ? linear_force_speed_limit
			: rotary_torque_speed_limit;
		ceiling = int_overspeed ? overspeed : max_speed;
		internal_limit = (prog_limit > ceiling) ? ceiling : prog_limit;
		next_limit = internal_limit;
		if (src_external && host_speed_limit_cmd < internal_limit)
			next_limit = host_speed_limit_cmd;
		next_near = abs_dev <= near_width;
		next_done = config_reg[CF_DONE_EN]
			&& abs_dev <= positioning_done_width;
		next_limit_flag = i_torque_mode && i_speed_cmd > next_limit;
	end

	always_comb
	begin
		near_alloc = 1'b0;
		vlt_alloc = 1'b0;
		case (amode)
			ALLOC_COMPAT:
			begin
				near_alloc = config_reg[CF_NEAR_COMPAT];
				vlt_alloc = config_reg[CF_VLT_COMPAT];
			end
			ALLOC_MULTI:
			begin
				near_alloc = config_reg[CF_NEAR_MULTI];
				vlt_alloc = config_reg[CF_VLT_MULTI];
			end
			default:
			begin
				near_alloc = 1'b0;
				vlt_alloc = 1'b0;
			end
		endcase
	end

	// restart-latched selections, taken while reset is held
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			src_external <= config_reg[CF_SRC_SEL];
			int_overspeed <= config_reg[CF_INT_SEL];
		end
	end

	// configuration registers
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			near_width <= NEAR_WIDTH_MAX;
			positioning_done_width <= DONE_WIDTH_DEF;
			config_reg <= CONFIG_DEF;
			rotary_torque_speed_limit <= TORQUE_LIMIT_DEF;
			linear_force_speed_limit <= TORQUE_LIMIT_DEF;
			max_speed <= MAX_SPEED_DEF;
			overspeed <= OVERSPEED_DEF;
			irq_mask <= '0;
		end
		else if (wr)
		begin
			if (paddr == A_NEAR_WIDTH)
				near_width <= (pwdata > NEAR_WIDTH_MAX) ? NEAR_WIDTH_MAX : pwdata;
			else if (paddr == A_DONE_WIDTH)
				positioning_done_width <= (pwdata > NEAR_WIDTH_MAX)
					? NEAR_WIDTH_MAX : pwdata;
			else if (paddr == A_CONFIG)
				config_reg <= pwdata[9:0];
			else if (paddr == A_ROT_LIMIT)
				rotary_torque_speed_limit <= (pwdata[15:0] > TORQUE_LIMIT_MAX)
					? TORQUE_LIMIT_MAX : pwdata[15:0];
			else if (paddr == A_LIN_LIMIT)
				linear_force_speed_limit <= (pwdata[15:0] > TORQUE_LIMIT_MAX)
					? TORQUE_LIMIT_MAX : pwdata[15:0];
			else if (paddr == A_MAX_SPEED)
				max_speed <= pwdata[15:0];
			else if (paddr == A_OVERSPEED)
				overspeed <= pwdata[15:0];
			else if (paddr == A_IRQ_MASK)
				irq_mask <= pwdata[NEV-1:0];
		end
	end

	// host limit command capture
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			host_speed_limit_cmd <= TORQUE_LIMIT_DEF;
		else if (i_ce && i_host_limit_valid)
			host_speed_limit_cmd <= i_host_speed_limit_cmd;
	end

	// flags and outputs, once per control cycle
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			near_flag <= 1'b0;
			done_flag <= 1'b0;
			limit_flag <= 1'b0;
			applied_limit <= '0;
			o_speed_ref <= '0;
			o_near_out <= 1'b0;
			o_positioning_done_out <= 1'b0;
			o_speed_limit_active_out <= 1'b0;
		end
		else if (i_ce)
		begin
			near_flag <= next_near;
			done_flag <= next_done;
			limit_flag <= next_limit_flag;
			applied_limit <= next_limit;
			o_speed_ref <= (i_torque_mode && next_limit_flag) ? next_limit
				: i_speed_cmd;
			o_near_out <= next_near && near_alloc;
			o_positioning_done_out <= next_done;
			o_speed_limit_active_out <= next_limit_flag && vlt_alloc;
		end
	end

	// sticky events: set wins over write-one-clear
	assign events = {next_limit_flag & ~limit_flag, next_done & ~done_flag,
		next_near & ~near_flag};

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			irq_stat <= '0;
		else if (i_ce)
			irq_stat <= (irq_stat & ~((wr && paddr == A_IRQ_STAT)
				? pwdata[NEV-1:0] : '0)) | events;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			o_irq <= 1'b0;
		else if (i_ce)
			o_irq <= |(irq_stat & irq_mask);
	end

	// apb read and handshake: one wait-free access phase
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (i_ce)
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				prdata <= '0;
				if (paddr[1:0] != 2'h0 || paddr > A_APPLIED)
					pslverr <= 1'b1;
				else if (!rd)
					prdata <= '0;
				else if (paddr == A_NEAR_WIDTH)
					prdata <= near_width;
				else if (paddr == A_DONE_WIDTH)
					prdata <= positioning_done_width;
				else if (paddr == A_CONFIG)
					prdata <= {22'h0, config_reg};
				else if (paddr == A_ROT_LIMIT)
					prdata <= {16'h0, rotary_torque_speed_limit};
				else if (paddr == A_LIN_LIMIT)
					prdata <= {16'h0, linear_force_speed_limit};
				else if (paddr == A_MAX_SPEED)
					prdata <= {16'h0, max_speed};
				else if (paddr == A_OVERSPEED)
					prdata <= {16'h0, overspeed};
				else if (paddr == A_HOST_LIMIT)
					prdata <= {16'h0, host_speed_limit_cmd};
				else if (paddr == A_STATUS)
					prdata <= {27'h0, int_overspeed, src_external,
						limit_flag, done_flag, near_flag};
				else if (paddr == A_IRQ_STAT)
					prdata <= {29'h0, irq_stat};
				else if (paddr == A_IRQ_MASK)
					prdata <= {29'h0, irq_mask};
				else
					prdata <= {16'h0, applied_limit};
			end
		end
	end

	property p_near;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && abs_dev <= near_width |=> near_flag;
	endproperty
	a_near: assert property (p_near) else $error("near not set");
	property p_near_out;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && !near_alloc |=> !o_near_out;
	endproperty
	a_near_out: assert property (p_near_out) else $error("near ungated");
	property p_done;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && config_reg[CF_DONE_EN] && abs_dev > positioning_done_width
			|=> !o_positioning_done_out;
	endproperty
	a_done: assert property (p_done) else $error("done wrong");
	property p_vlt;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && !i_torque_mode |=> !o_speed_limit_active_out;
	endproperty
	a_vlt: assert property (p_vlt) else $error("limit outside torque");
	property p_min;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce |=> applied_limit <= $past(internal_limit);
	endproperty
	a_min: assert property (p_min) else $error("limit above internal");
	property p_ceil;
		@(posedge i_mclk) disable iff (!i_rst_n)
		internal_limit <= ceiling;
	endproperty
	a_ceil: assert property (p_ceil) else $error("ceiling exceeded");
	property p_ref;
		@(posedge i_mclk) disable iff (!i_rst_n)
		i_ce && i_torque_mode |=> o_speed_ref <= applied_limit;
	endproperty
	a_ref: assert property (p_ref) else $error("speed ref unlimited");
	property p_rot;
		@(posedge i_mclk) disable iff (!i_rst_n)
		rotary_torque_speed_limit <= TORQUE_LIMIT_MAX;
	endproperty
	a_rot: assert property (p_rot) else $error("rotary limit range");
	c_near: cover property (@(posedge i_mclk) o_near_out ##1 !o_near_out);
	c_vlt: cover property (@(posedge i_mclk) o_speed_limit_active_out);
	c_irq: cover property (@(posedge i_mclk) o_irq);
endmodule

/* File: host_link_model.sv */
// host controller model that sends speed limit commands over the link
`timescale 1ns/1ps
module host_link_model
(
	input  wire logic        i_mclk,
	input  wire logic        i_send,
	input  wire logic [15:0] i_value,
	output logic      [15:0] o_cmd,
	output logic             o_valid
);
	// one-cycle command; idle value is inverted so stale data never matches
	always @(posedge i_mclk)
	begin
		o_valid <= i_send;
		o_cmd <= i_send ? i_value : ~i_value;
	end
endmodule

/* File: test_near_flag_and_torque_speed_limit.sv */
// self-checking bench for the near flag and torque speed limit block
`timescale 1ns/1ps
module test_near_flag_and_torque_speed_limit;
	import near_limit_pkg::*;
	logic              i_mclk = 1'b0;
	logic              i_rst_n = 1'b0;
	logic              i_ce = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0000_0000;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic signed [DEV_W-1:0] i_deviation = 32'sh0;
	logic              i_torque_mode = 1'b0;
	logic [SPD_W-1:0]  i_speed_cmd = 16'h0000;
	logic [SPD_W-1:0]  i_host_speed_limit_cmd;
	logic              i_host_limit_valid;
	logic [SPD_W-1:0]  o_speed_ref;
	logic              o_near_out;
	logic              o_positioning_done_out;
	logic              o_speed_limit_active_out;
	logic              o_irq;
	logic              send = 1'b0;
	logic [15:0]       send_val = 16'h0000;
	logic [31:0]       rd;
	logic              err;
	int                n_errors = 0;
	int                n_compared = 0;

	always #20 i_mclk = ~i_mclk;

	near_flag_and_torque_speed_limit dut_u
	(
		.i_mclk, .i_rst_n, .i_ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .i_deviation,
		.i_torque_mode, .i_speed_cmd, .i_host_speed_limit_cmd,
		.i_host_limit_valid, .o_speed_ref, .o_near_out,
		.o_positioning_done_out, .o_speed_limit_active_out, .o_irq
	);

	host_link_model host_u
	(
		.i_mclk, .i_send(send), .i_value(send_val),
		.o_cmd(i_host_speed_limit_cmd), .o_valid(i_host_limit_valid)
	);

	task automatic stop_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge i_mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge i_mclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			n_errors++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// drive a deviation and let the registered flags follow
	task automatic setdev(input int v);
		@(posedge i_mclk);
		i_deviation <= 32'(v);
		repeat (2) @(posedge i_mclk);
		#1;
	endtask

	function automatic logic near_exp(input int v, input int w);
		return ((v < 0) ? -v : v) <= w;
	endfunction

	function automatic int lim_exp(input int h, input int r, input int m);
		int t;
		t = (r < m) ? r : m;
		return (h < t) ? h : t;
	endfunction

	initial
	begin
		int dc[8] = '{-100, 100, 101, -101, 7, 8, -8, 0};
		int cr[4] = '{5000, 5000, 10000, 5000};
		int cm[4] = '{10000, 10000, 8000, 10000};
		int ch[4] = '{9000, 9000, 9500, 2000};
		int v;
		int lim;
		logic [15:0] c;
		logic [31:0] e;
		void'($urandom(32'hBDF0FD5C));
		repeat (6) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rdc(A_NEAR_WIDTH, 32'h4000_0000);
		rdc(A_DONE_WIDTH, 32'h0000_0007);
		rdc(A_ROT_LIMIT, 32'h0000_2710);
		rdc(A_LIN_LIMIT, 32'h0000_2710);
		apb(1'b1, 12'h030, 32'h0000_0001);
		chk(32'(err), 32'h0000_0001);
		apb(1'b1, A_NEAR_WIDTH, 32'hFFFF_FFFF);
		rdc(A_NEAR_WIDTH, 32'h4000_0000);
		apb(1'b1, A_ROT_LIMIT, 32'h0000_FFFF);
		rdc(A_ROT_LIMIT, 32'h0000_2710);
		apb(1'b1, A_CONFIG, 32'h0000_02A5);
		apb(1'b1, A_NEAR_WIDTH, 32'h0000_0064);
		for (int i = 0; i < 32; i++)
		begin
			v = (i < 8) ? dc[i] : int'($urandom_range(400)) - 200;
			setdev(v);
			chk(32'(o_near_out), 32'(near_exp(v, 100)));
			chk(32'(o_positioning_done_out), 32'(near_exp(v, 7)));
		end
		apb(1'b1, A_CONFIG, 32'h0000_02A6);
		setdev(0);
		chk(32'(o_near_out), 32'h0000_0000);
		apb(1'b1, A_CONFIG, 32'h0000_0346);
		setdev(0);
		chk(32'(o_near_out), 32'h0000_0001);
		// clock enable low: flags must hold
		@(posedge i_mclk);
		i_ce <= 1'b0;
		setdev(1000);
		chk(32'(o_near_out), 32'h0000_0001);
		@(posedge i_mclk);
		i_ce <= 1'b1;
		setdev(1000);
		chk(32'(o_near_out), 32'h0000_0000);
		apb(1'b1, A_CONFIG, 32'h0000_02A5);
		setdev(1000);
		apb(1'b1, A_IRQ_MASK, 32'h0000_0007);
		apb(1'b1, A_IRQ_STAT, 32'h0000_0007);
		rdc(A_IRQ_STAT, 32'h0000_0000);
		// a mask bit set high lets its status bit through
		setdev(0);
		chk(32'(o_irq), 32'h0000_0001);
		rdc(A_IRQ_STAT, 32'h0000_0003);
		apb(1'b1, A_IRQ_MASK, 32'h0000_0000);
		setdev(0);
		chk(32'(o_irq), 32'h0000_0000);
		apb(1'b1, A_IRQ_MASK, 32'h0000_0007);
		setdev(0);
		chk(32'(o_irq), 32'h0000_0001);
		apb(1'b1, A_IRQ_STAT, 32'h0000_0003);
		setdev(0);
		chk(32'(o_irq), 32'h0000_0000);
		rdc(A_STATUS, 32'h0000_000B);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, A_CONFIG, (k == 1) ? 32'h0000_02B5 : 32'h0000_02A5);
			apb(1'b1, A_ROT_LIMIT, 32'(cr[k]));
			apb(1'b1, A_LIN_LIMIT, 32'h0000_0FA0);
			apb(1'b1, A_MAX_SPEED, 32'(cm[k]));
			@(posedge i_mclk);
			send <= 1'b1;
			send_val <= 16'(ch[k]);
			@(posedge i_mclk);
			send <= 1'b0;
			rdc(A_HOST_LIMIT, 32'(ch[k]));
			lim = lim_exp(ch[k], (k == 1) ? 4000 : cr[k], cm[k]);
			rdc(A_APPLIED, 32'(lim));
			for (int j = 0; j < 6; j++)
			begin
				c = (j == 3) ? 16'(lim) : 16'($urandom_range(12000));
				@(posedge i_mclk);
				i_speed_cmd <= c;
				i_torque_mode <= j[0];
				repeat (2) @(posedge i_mclk);
				#1;
				e = (j[0] && c > lim) ? 32'(lim) : 32'(c);
				chk(32'(o_speed_ref), e);
				e = 32'(j[0] && c > lim);
				chk(32'(o_speed_limit_active_out), e);
			end
		end
		stop_test();
	end
endmodule
